// File: logic/gptu_top.sv
// general purpose timer unit: five timers in two groups behind an APB slave
`timescale 1ns/1ps
`include "gptu_params.svh"
// Notes on behaviour
// RULE1: five 16-bit up/down timers, two groups
// RULE2: first group modes: timer, gated, counter, incremental
// RULE3: timer mode counts prescaled system clock
// RULE4: counter mode counts input pin events
// RULE5: gated mode counts only at gate level
// RULE6: first group steps at most every 4 cycles
// RULE7: direction from control bit or pin
// RULE8: incremental mode decodes quadrature A and B
// RULE9: core overflow toggles latch, optional output
// RULE10: core latch can clock auxiliary timers
// RULE11: auxiliary timer in capture/reload role stops
// RULE12: capture copies core value on pin event
// RULE13: reload core on pin or latch transition
// RULE14: two reload registers alternate for PWM
// RULE15: second group steps at most every 2 cycles
// RULE16: second group prescaled clock or external input
// RULE17: second core overflow toggles second latch
// RULE18: second core overflow clocks compare, reloads
// RULE19: capture second aux on pin, optional clear
// RULE20: capture also from core input pins
// RULE21: overflows and captures set request flags
// RULE22: all pins synchronised before detection
module gptu_top (
   input  wire logic        REF_CLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic [4:0]  TIN_I,
   input  wire logic [4:0]  TDIR_I,
   input  wire logic        CAPTURE_INPUT_PIN_I,
   output logic             CORE_TOGGLE_O,
   output logic             SECOND_TOGGLE_O,
   output logic             SECOND_CLK_O,
   output gptu_pkg::gptu_req_t REQ_O
);
   import gptu_pkg::*;

   gptu_ctrl_t   ctrl_reg [`GPTU_NUM_TMR];
   logic [15:0]  cnt_reg  [`GPTU_NUM_TMR];
   logic [15:0]  load_val [`GPTU_NUM_TMR];
   gptu_crctrl_t crctrl_reg;
   logic [15:0]  capture_reload_reg_reg;
   logic [15:0]  pre_cnt_reg;
   logic [4:0]   tin_s1, tin_s2, tin_s3;
   logic [4:0]   tdir_s1, tdir_s2, tdir_s3;
   logic         cap_s1, cap_s2, cap_s3;
   logic         core_latch_reg;
   logic         second_latch_reg;
   logic [4:0]   pend_reg;
   logic [4:0]   pdir_reg;
   logic [4:0]   step, ovf, cnt_wr, load_en, pin_evt, quad_evt, quad_down;
   logic [4:0]   tin_rise, tin_fall, tdir_chg;
   logic         cap_rise, cap_fall;
   logic         core_lat_rise, core_lat_fall, sec_lat_rise, sec_lat_fall;
   logic         rel_a, rel_b, cap_a, cap_b, capture_reload_reg_evt;
   logic         cr_rise, cr_fall;
   logic         apb_take, apb_wr, hit_ctrl, hit_cnt, hit_misc;
   logic [2:0]   apb_idx;

   // RULE22: two-stage synchronisers
   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         {tin_s1, tin_s2, tin_s3}    <= 15'h0000;
         {tdir_s1, tdir_s2, tdir_s3} <= 15'h0000;
         {cap_s1, cap_s2, cap_s3}    <= 3'h0;
      end
      else
      begin
         {tin_s3, tin_s2, tin_s1}    <= {tin_s2, tin_s1, TIN_I};
         {tdir_s3, tdir_s2, tdir_s1} <= {tdir_s2, tdir_s1, TDIR_I};
         {cap_s3, cap_s2, cap_s1}    <= {cap_s2, cap_s1, CAPTURE_INPUT_PIN_I};
      end
   end

   assign tin_rise = tin_s2 & ~tin_s3;
   assign tin_fall = ~tin_s2 & tin_s3;
   assign tdir_chg = tdir_s2 ^ tdir_s3;
   assign cap_rise = cap_s2 & ~cap_s3;
   assign cap_fall = ~cap_s2 & cap_s3;

   // free-running prescaler; every rate is a mask on it
   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
         pre_cnt_reg <= 16'h0000;
      else
         pre_cnt_reg <= pre_cnt_reg + 16'h0001;
   end

   // latch transitions are known in the overflow cycle itself
   assign core_lat_rise = ovf[`GPTU_IDX_CORE] & ~core_latch_reg;
   assign core_lat_fall = ovf[`GPTU_IDX_CORE] & core_latch_reg;
   assign sec_lat_rise  = ovf[`GPTU_IDX_SCORE] & ~second_latch_reg;
   assign sec_lat_fall  = ovf[`GPTU_IDX_SCORE] & second_latch_reg;

   // RULE1: one slice per timer
   for (genvar gi = 0; gi < `GPTU_NUM_TMR; gi++)
   begin : g_tmr
      localparam logic G1 = (5'(gi) < `GPTU_NUM_G1);
      localparam logic [15:0] RES = G1 ? `GPTU_G1_RES : `GPTU_G2_RES;
      gptu_ctrl_t  c;
      logic [15:0] mask;
      logic        ptick, btick, lat_evt, src_evt, gate_ok, down, evt;
      assign c = ctrl_reg[gi];
      // RULE3: programmable prescale of system clock
      assign mask  = (RES << c.prescale) - 16'h0001;
      assign ptick = (pre_cnt_reg & mask) == 16'h0000;
      // RULE6: group one base rate
      // RULE15: group two base rate
      assign btick = (pre_cnt_reg & (RES - 16'h0001)) == 16'h0000;
      assign pin_evt[gi] = (c.edge_sel[0] & tin_rise[gi]) | (c.edge_sel[1] & tin_fall[gi]);
      // RULE10: core latch clocks auxiliary timers
      // RULE17: second latch clocks second aux
      if (gi == `GPTU_IDX_AUXA || gi == `GPTU_IDX_AUXB)
      begin : g_lat1
         assign lat_evt = (c.edge_sel[0] & core_lat_rise) | (c.edge_sel[1] & core_lat_fall);
      end
      else if (gi == `GPTU_IDX_SAUX)
      begin : g_lat2
         assign lat_evt = (c.edge_sel[0] & sec_lat_rise) | (c.edge_sel[1] & sec_lat_fall);
      end
      else
      begin : g_nolat
         assign lat_evt = 1'b0;
      end
      // RULE4: counter source pin or latch
      // RULE16: external or prescaled clock
      assign src_evt = c.latch_clk ? lat_evt : pin_evt[gi];
      // RULE8: quadrature decode, A leading B counts up
      assign quad_evt[gi]  = G1 & (tin_rise[gi] | tin_fall[gi] | tdir_chg[gi]);
      assign quad_down[gi] = tin_s3[gi] ^ tdir_s2[gi];
      assign evt = (c.mode == MODE_COUNTER) ? src_evt :
                   (c.mode == MODE_INCR) ? quad_evt[gi] : 1'b0;
      // RULE5: gate level enables counting
      assign gate_ok = (tin_s2[gi] == c.gate_hi);
      // RULE7: direction from bit or pin
      assign down = (c.mode == MODE_INCR) ? pdir_reg[gi] :
                    c.dir_ext ? tdir_s2[gi] : c.dir_down;
      // RULE2: per-timer mode select
      // RULE11: capture or reload role stops counting
      always_comb
      begin
         step[gi] = 1'b0;
         if (c.run && c.role == ROLE_NORMAL)
         begin
            case (c.mode)
               MODE_TIMER:   step[gi] = ptick;
               MODE_GATED:   step[gi] = ptick & gate_ok;
               MODE_COUNTER: step[gi] = btick & pend_reg[gi];
               MODE_INCR:    step[gi] = btick & pend_reg[gi];
               default:      step[gi] = 1'b0;
            endcase
         end
      end
      assign ovf[gi] = step[gi] & (down ? (cnt_reg[gi] == `GPTU_CNT_RST) : (cnt_reg[gi] == `GPTU_CNT_MAX));

      // events wait for the base tick, so fast pins never exceed the resolution
      always_ff @(posedge REF_CLK_I)
      begin
         if (SYS_RST_I)
         begin
            pend_reg[gi] <= 1'b0;
            pdir_reg[gi] <= 1'b0;
         end
         else
         begin
            pend_reg[gi] <= evt | (pend_reg[gi] & ~btick);
            if (quad_evt[gi])
               pdir_reg[gi] <= quad_down[gi];
         end
      end

      always_ff @(posedge REF_CLK_I)
      begin
         if (SYS_RST_I)
            cnt_reg[gi] <= `GPTU_CNT_RST;
         else if (load_en[gi])
            cnt_reg[gi] <= load_val[gi];
         else if (step[gi])
            cnt_reg[gi] <= down ? cnt_reg[gi] - 16'h0001 : cnt_reg[gi] + 16'h0001;
      end
   end

   // RULE12: capture into auxiliary timers
   assign cap_a = (ctrl_reg[`GPTU_IDX_AUXA].role == ROLE_CAPTURE) & pin_evt[`GPTU_IDX_AUXA];
   assign cap_b = (ctrl_reg[`GPTU_IDX_AUXB].role == ROLE_CAPTURE) & pin_evt[`GPTU_IDX_AUXB];
   // RULE13: reload on pin or latch edge
   // RULE14: opposite latch edges alternate reloads
   assign rel_a = (ctrl_reg[`GPTU_IDX_AUXA].role == ROLE_RELOAD)
                & (pin_evt[`GPTU_IDX_AUXA]
                   | (ctrl_reg[`GPTU_IDX_AUXA].rel_rise & core_lat_rise)
                   | (ctrl_reg[`GPTU_IDX_AUXA].rel_fall & core_lat_fall));
   assign rel_b = (ctrl_reg[`GPTU_IDX_AUXB].role == ROLE_RELOAD)
                & (pin_evt[`GPTU_IDX_AUXB]
                   | (ctrl_reg[`GPTU_IDX_AUXB].rel_rise & core_lat_rise)
                   | (ctrl_reg[`GPTU_IDX_AUXB].rel_fall & core_lat_fall));

   // RULE20: capture source select
   always_comb
   begin
      case (crctrl_reg.src)
         CSRC_CAPTURE_INPUT_PIN:    {cr_rise, cr_fall} = {cap_rise, cap_fall};
         CSRC_CORE_IN:  {cr_rise, cr_fall} = {tin_rise[`GPTU_IDX_CORE], tin_fall[`GPTU_IDX_CORE]};
         CSRC_CORE_DIR: {cr_rise, cr_fall} = {tdir_s2[`GPTU_IDX_CORE] & ~tdir_s3[`GPTU_IDX_CORE],
                                              ~tdir_s2[`GPTU_IDX_CORE] & tdir_s3[`GPTU_IDX_CORE]};
         default:       {cr_rise, cr_fall} = {tin_rise[`GPTU_IDX_CORE] | (tdir_s2[`GPTU_IDX_CORE] & ~tdir_s3[`GPTU_IDX_CORE]),
                                              tin_fall[`GPTU_IDX_CORE] | (~tdir_s2[`GPTU_IDX_CORE] & tdir_s3[`GPTU_IDX_CORE])};
      endcase
   end
   // RULE19: capture on selected transition
   assign capture_reload_reg_evt = (crctrl_reg.edge_sel[0] & cr_rise) | (crctrl_reg.edge_sel[1] & cr_fall);

   // APB decode; a software write beats every hardware load of a counter or the capture register
   assign apb_take = PSEL_I & PENABLE_I & PREADY_O;
   assign apb_idx  = PADDR_I[4:2];
   assign hit_ctrl = (PADDR_I[7:5] == 3'(`GPTU_CTRL_BASE >> 5)) & (apb_idx < 3'(`GPTU_NUM_TMR));
   assign hit_cnt  = (PADDR_I[7:5] == 3'(`GPTU_CNT_BASE >> 5)) & (apb_idx < 3'(`GPTU_NUM_TMR));
   assign hit_misc = (PADDR_I == `GPTU_CAPTURE_RELOAD_REG_OFS) | (PADDR_I == `GPTU_CRCTRL_OFS) | (PADDR_I == `GPTU_FLAGS_OFS);
   assign apb_wr   = apb_take & PWRITE_I;

   always_comb
   begin
      for (int i = 0; i < `GPTU_NUM_TMR; i++)
         cnt_wr[i] = apb_wr & hit_cnt & (apb_idx == 3'(i));
      load_en  = cnt_wr;
      for (int i = 0; i < `GPTU_NUM_TMR; i++)
         load_val[i] = PWDATA_I[15:0];
      if (!cnt_wr[`GPTU_IDX_CORE] && (rel_a || rel_b))
      begin
         load_en[`GPTU_IDX_CORE]  = 1'b1;
         load_val[`GPTU_IDX_CORE] = rel_a ? cnt_reg[`GPTU_IDX_AUXA] : cnt_reg[`GPTU_IDX_AUXB];
      end
      if (!cnt_wr[`GPTU_IDX_AUXA] && cap_a)
      begin
         load_en[`GPTU_IDX_AUXA]  = 1'b1;
         load_val[`GPTU_IDX_AUXA] = cnt_reg[`GPTU_IDX_CORE];
      end
      if (!cnt_wr[`GPTU_IDX_AUXB] && cap_b)
      begin
         load_en[`GPTU_IDX_AUXB]  = 1'b1;
         load_val[`GPTU_IDX_AUXB] = cnt_reg[`GPTU_IDX_CORE];
      end
      // RULE19: optional clear after capture
      if (!cnt_wr[`GPTU_IDX_SAUX] && capture_reload_reg_evt && crctrl_reg.clear_aux)
      begin
         load_en[`GPTU_IDX_SAUX]  = 1'b1;
         load_val[`GPTU_IDX_SAUX] = `GPTU_CNT_RST;
      end
      // RULE18: reload second core from capture register
      if (!cnt_wr[`GPTU_IDX_SCORE] && ovf[`GPTU_IDX_SCORE] && crctrl_reg.reload_en)
      begin
         load_en[`GPTU_IDX_SCORE]  = 1'b1;
         load_val[`GPTU_IDX_SCORE] = capture_reload_reg_reg;
      end
   end

   always_ff @(posedge REF_CLK_I)
   begin
      for (int i = 0; i < `GPTU_NUM_TMR; i++)
      begin
         if (SYS_RST_I)
            ctrl_reg[i] <= `GPTU_CTRL_RST;
         else if (apb_wr && hit_ctrl && apb_idx == 3'(i))
            ctrl_reg[i] <= PWDATA_I[16:0];
      end
   end

   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         crctrl_reg <= `GPTU_CRCTRL_RST;
         capture_reload_reg_reg <= `GPTU_CNT_RST;
      end
      else
      begin
         if (apb_wr && PADDR_I == `GPTU_CRCTRL_OFS)
            crctrl_reg <= PWDATA_I[5:0];
         if (apb_wr && PADDR_I == `GPTU_CAPTURE_RELOAD_REG_OFS)
            capture_reload_reg_reg <= PWDATA_I[15:0];
         else if (capture_reload_reg_evt)
            capture_reload_reg_reg <= cnt_reg[`GPTU_IDX_SAUX];
      end
   end

   // RULE9: core toggle latch
   // RULE17: second toggle latch
   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         core_latch_reg   <= 1'b0;
         second_latch_reg <= 1'b0;
         CORE_TOGGLE_O    <= 1'b0;
         SECOND_TOGGLE_O  <= 1'b0;
         SECOND_CLK_O     <= 1'b0;
      end
      else
      begin
         core_latch_reg   <= core_latch_reg ^ ovf[`GPTU_IDX_CORE];
         second_latch_reg <= second_latch_reg ^ ovf[`GPTU_IDX_SCORE];
         // pin lags latch one cycle so the output stays a plain flop
         CORE_TOGGLE_O    <= ctrl_reg[`GPTU_IDX_CORE].out_en & core_latch_reg;
         SECOND_TOGGLE_O  <= ctrl_reg[`GPTU_IDX_SCORE].out_en & second_latch_reg;
         // RULE18: clock pulse to compare unit
         SECOND_CLK_O     <= ovf[`GPTU_IDX_SCORE];
      end
   end

   // RULE21: sticky flags, set wins over clear
   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
         REQ_O <= '0;
      else
         REQ_O <= ({cap_b, cap_a, capture_reload_reg_evt, ovf})
                | (REQ_O & ~((apb_wr && PADDR_I == `GPTU_FLAGS_OFS) ? PWDATA_I[7:0] : 8'h00));
   end

   // slave answers one cycle into the access phase
   always_ff @(posedge REF_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h00000000;
      end
      else
      begin
         PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
         PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & ~(hit_ctrl | hit_cnt | hit_misc);
         PRDATA_O  <= 32'h00000000;
         if (PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I)
         begin
            if (hit_ctrl)
               PRDATA_O <= {15'h0000, ctrl_reg[apb_idx]};
            else if (hit_cnt)
               PRDATA_O <= {16'h0000, cnt_reg[apb_idx]};
            else if (PADDR_I == `GPTU_CAPTURE_RELOAD_REG_OFS)
               PRDATA_O <= {16'h0000, capture_reload_reg_reg};
            else if (PADDR_I == `GPTU_CRCTRL_OFS)
               PRDATA_O <= {26'h0000000, crctrl_reg};
            else if (PADDR_I == `GPTU_FLAGS_OFS)
               PRDATA_O <= {24'h000000, REQ_O};
         end
      end
   end

   AST_G1_SPACING: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I) // RULE6
      step[`GPTU_IDX_CORE] |=> !step[`GPTU_IDX_CORE] [*3])
      else $error("core timer stepped faster than every 4 cycles");
   AST_G2_SPACING: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I) // RULE15
      step[`GPTU_IDX_SCORE] |=> !step[`GPTU_IDX_SCORE])
      else $error("second core stepped faster than every 2 cycles");
   AST_CORE_TOGGLE: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I) // RULE9
      ovf[`GPTU_IDX_CORE] |=> core_latch_reg != $past(core_latch_reg) ##1
      CORE_TOGGLE_O == (ctrl_reg[`GPTU_IDX_CORE].out_en & $past(core_latch_reg)))
      else $error("core toggle latch or output wrong after overflow");
   AST_CAPTURE_COPY: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I) // RULE12
      cap_a && !cnt_wr[`GPTU_IDX_AUXA] |=> cnt_reg[`GPTU_IDX_AUXA] == $past(cnt_reg[`GPTU_IDX_CORE]))
      else $error("aux timer a did not capture core value");
   AST_ROLE_STOP: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I) // RULE11
      ctrl_reg[`GPTU_IDX_AUXB].role != ROLE_NORMAL && !load_en[`GPTU_IDX_AUXB]
      |=> cnt_reg[`GPTU_IDX_AUXB] == $past(cnt_reg[`GPTU_IDX_AUXB]))
      else $error("aux timer b counted while in capture or reload role");
   AST_RELOAD_CORE: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I) // RULE13
      rel_b && !rel_a && !cnt_wr[`GPTU_IDX_CORE] |=> cnt_reg[`GPTU_IDX_CORE] == $past(cnt_reg[`GPTU_IDX_AUXB]))
      else $error("core timer not reloaded from aux timer b");
   AST_CAPTURE_RELOAD_REG: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I) // RULE19
      capture_reload_reg_evt && crctrl_reg.clear_aux && !apb_wr
      |=> capture_reload_reg_reg == $past(cnt_reg[`GPTU_IDX_SAUX]) && cnt_reg[`GPTU_IDX_SAUX] == `GPTU_CNT_RST)
      else $error("capture register or clear of second aux wrong");
   AST_SECOND_CLK: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I) // RULE18
      ovf[`GPTU_IDX_SCORE] |=> SECOND_CLK_O ##1 !SECOND_CLK_O || ovf[`GPTU_IDX_SCORE])
      else $error("second core overflow pulse missing");
   AST_FLAG_SET: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I) // RULE21
      (|ovf) |=> (REQ_O.ovf & $past(ovf)) == $past(ovf))
      else $error("overflow flag not set after overflow");
endmodule : gptu_top

// File: include/gptu_params.svh
// offsets, field resets and timing counts of the general purpose timer unit
`ifndef GPTU_PARAMS_SVH
`define GPTU_PARAMS_SVH
`define GPTU_CTRL_BASE   8'h00
`define GPTU_CNT_BASE    8'h20
`define GPTU_CAPTURE_RELOAD_REG_OFS  8'h40
`define GPTU_CRCTRL_OFS  8'h44
`define GPTU_FLAGS_OFS   8'h48
`define GPTU_NUM_TMR     5
`define GPTU_NUM_G1      5'd3
`define GPTU_IDX_AUXA    0
`define GPTU_IDX_CORE    1
`define GPTU_IDX_AUXB    2
`define GPTU_IDX_SAUX    3
`define GPTU_IDX_SCORE   4
`define GPTU_G1_RES      16'h0004
`define GPTU_G2_RES      16'h0002
`define GPTU_CTRL_RST    17'h00000
`define GPTU_CRCTRL_RST  6'h00
`define GPTU_CNT_RST     16'h0000
`define GPTU_CNT_MAX     16'hFFFF
`endif

// File: include/gptu_pkg.sv
// types of the general purpose timer unit
package gptu_pkg;
   typedef enum logic [1:0] {
      MODE_TIMER   = 2'h0,
      MODE_COUNTER = 2'h1,
      MODE_GATED   = 2'h2,
      MODE_INCR    = 2'h3
   } gptu_mode_t;

   typedef enum logic [1:0] {
      ROLE_NORMAL  = 2'h0,
      ROLE_CAPTURE = 2'h1,
      ROLE_RELOAD  = 2'h2,
      ROLE_SPARE   = 2'h3
   } gptu_role_t;

   typedef enum logic [1:0] {
      CSRC_CAPTURE_INPUT_PIN    = 2'h0,
      CSRC_CORE_IN  = 2'h1,
      CSRC_CORE_DIR = 2'h2,
      CSRC_CORE_ANY = 2'h3
   } gptu_csrc_t;

   typedef struct packed {
      logic       out_en;
      logic [2:0] prescale;
      logic       rel_fall;
      logic       rel_rise;
      logic       latch_clk;
      gptu_role_t role;
      logic [1:0] edge_sel;
      logic       gate_hi;
      logic       run;
      logic       dir_ext;
      logic       dir_down;
      gptu_mode_t mode;
   } gptu_ctrl_t;

   typedef struct packed {
      logic       reload_en;
      logic       clear_aux;
      logic [1:0] edge_sel;
      gptu_csrc_t src;
   } gptu_crctrl_t;

   typedef struct packed {
      logic       capt_b;
      logic       capt_a;
      logic       capture_reload_reg;
      logic [4:0] ovf;
   } gptu_req_t;
endpackage : gptu_pkg

// File: testbench/gptu_pins.sv
// pin-side model: event pulses, levels and a quadrature sensor
`timescale 1ns/1ps
module gptu_pins (
   input  wire logic       clk_i,
   output logic      [4:0] tin_o,
   output logic      [4:0] tdir_o,
   output logic            capture_input_pin_o
);
   initial
   begin
      tin_o = 5'h00;
      tdir_o = 5'h00;
      capture_input_pin_o = 1'b0;
   end

   // k flips of one pin (p: 0 timer in, 1 direction, 2 capture), w+1 cycles apart
   task pulse(input int p, input int i, input int w, input int k);
      repeat (k)
      begin
         @(posedge clk_i);
         if (p == 0)
            tin_o[i] <= ~tin_o[i];
         else if (p == 1)
            tdir_o[i] <= ~tdir_o[i];
         else
            capture_input_pin_o <= ~capture_input_pin_o;
         repeat (w) @(posedge clk_i);
      end
   endtask : pulse

   // gray steps, forward has A leading B
   task quad(input logic fwd, input int n);
      repeat (n * 4)
      begin
         @(posedge clk_i);
         if ((tin_o[1] ^ tdir_o[1]) ^ fwd)
            tin_o[1] <= ~tin_o[1];
         else
            tdir_o[1] <= ~tdir_o[1];
         repeat (5) @(posedge clk_i);
      end
   endtask : quad
endmodule : gptu_pins

// File: testbench/gptu_top_tb.sv
// self-checking bench of the general purpose timer unit
`timescale 1ns/1ps
`include "gptu_params.svh"
module gptu_top_tb;
   import gptu_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [4:0]  tin;
   logic [4:0]  tdir;
   logic        capture_input_pin;
   logic        ctog;
   logic        stog;
   logic        sclk;
   gptu_req_t   req;
   int          mismatches = 0;
   int          total_checks = 0;
   int          seed = 65349;
   int          mdl [0:31];
   logic [31:0] rd;
   logic        er;
   logic [15:0] c0;
   int          n;

   always #10 clk = ~clk;

   gptu_top u_gptu_top (
      .REF_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .TIN_I(tin), .TDIR_I(tdir),
      .CAPTURE_INPUT_PIN_I(capture_input_pin), .CORE_TOGGLE_O(ctog), .SECOND_TOGGLE_O(stog),
      .SECOND_CLK_O(sclk), .REQ_O(req)
   );

   gptu_pins u_gptu_pins (.clk_i(clk), .tin_o(tin), .tdir_o(tdir), .capture_input_pin_o(capture_input_pin));

   function automatic logic [7:0] ca(input int i);
      return `GPTU_CNT_BASE + 8'(4 * i);
   endfunction : ca

   function automatic logic [7:0] cr(input int i);
      return `GPTU_CTRL_BASE + 8'(4 * i);
   endfunction : cr

   function automatic int msk(input int i);
      return (i < 5) ? 32'h1FFFF : (i == 17) ? 32'h3F : (i == 18) ? 32'hFF : 32'hFFFF;
   endfunction : msk

   task stop_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task chr(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
      total_checks++;
      if ((g >= lo && g <= hi) !== 1'b1)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h to %h", $time, g, lo, hi);
      end
   endtask : chr

   // setup, access, then hold until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a hung wait
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input int d);
      apb(1'b1, a, d);
      if (a == `GPTU_FLAGS_OFS)
         mdl[18] &= ~d;
      else
         mdl[a[6:2]] = d & msk(a[6:2]);
   endtask : wr

   task rc(input logic [7:0] a);
      apb(1'b0, a, 32'h00000000);
      chk(rd, mdl[a[6:2]]);
   endtask : rc

   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      stop_test();
   end

   initial
   begin
      for (int i = 0; i < 32; i++)
         mdl[i] = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 19; i++)
      begin
         rc(8'(4 * i));
         chk(er, (i % 8 > 4 && i < 16));
      end
      apb(1'b1, 8'h4C, 32'hFFFFFFFF);
      rc(8'h4C);
      chk(er, 1'b1);
      for (int i = 0; i < 5; i++)
      begin
         wr(ca(i), $random(seed));
         rc(ca(i));
         if (i < 3)
         begin
            wr(cr(i), $random(seed) & 32'hFFFEFFEF);
            rc(cr(i));
            wr(cr(i), 0);
         end
      end
      $display("test registers done");
      wr(ca(1), 32'hFFF0);
      wr(ca(4), 32'hFFF0);
      wr(cr(1), 32'h10010);
      wr(cr(4), 32'h10010);
      n = 0;
      repeat (80) @(posedge clk) n += sclk;
      chk(n, 1);
      chk(ctog, 1'b1);
      chk(stog, 1'b1);
      chk(32'(req), 32'h12);
      // both reads share latency, so the gap is exactly 40 cycles
      for (int i = 1; i < 5; i += 3)
      begin
         apb(1'b0, ca(i), 0);
         c0 = rd[15:0];
         repeat (36) @(posedge clk);
         apb(1'b0, ca(i), 0);
         chk(16'(rd[15:0] - c0), (i == 1) ? 10 : 20);
         wr(cr(i), 0);
      end
      mdl[18] = 32'h12;
      rc(`GPTU_FLAGS_OFS);
      wr(`GPTU_FLAGS_OFS, 32'hFF);
      rc(`GPTU_FLAGS_OFS);
      wr(ca(2), 3);
      wr(cr(2), 32'h14);
      repeat (30) @(posedge clk);
      chk(32'(req), 32'h04);
      wr(cr(2), 0);
      wr(`GPTU_FLAGS_OFS, 32'hFF);
      $display("test timer done");
      wr(ca(0), 0);
      wr(cr(0), 32'h59);
      repeat (5) u_gptu_pins.pulse(0, 0, 6, 2);
      mdl[8] = 5;
      rc(ca(0));
      u_gptu_pins.pulse(1, 0, 6, 1);
      repeat (2) u_gptu_pins.pulse(0, 0, 6, 2);
      mdl[8] = 3;
      rc(ca(0));
      u_gptu_pins.pulse(1, 0, 6, 1);
      wr(cr(0), 0);
      wr(ca(2), 0);
      wr(cr(2), 32'h32);
      repeat (40) @(posedge clk);
      rc(ca(2));
      u_gptu_pins.pulse(0, 2, 40, 2);
      apb(1'b0, ca(2), 0);
      chr(rd, 9, 11);
      wr(cr(2), 0);
      wr(ca(1), 32'h100);
      wr(cr(1), 32'hD3);
      u_gptu_pins.quad(1'b1, 4);
      repeat (4) @(posedge clk);
      mdl[9] = 32'h110;
      rc(ca(1));
      u_gptu_pins.quad(1'b0, 4);
      repeat (4) @(posedge clk);
      mdl[9] = 32'h100;
      rc(ca(1));
      wr(cr(1), 0);
      $display("test pin modes done");
      wr(ca(1), 32'h1234);
      wr(ca(0), 9);
      wr(cr(0), 32'h150);
      repeat (20) @(posedge clk);
      rc(ca(0));
      u_gptu_pins.pulse(0, 0, 6, 2);
      mdl[8] = 32'h1234;
      rc(ca(0));
      wr(ca(2), 32'hABCD);
      wr(cr(2), 32'h250);
      u_gptu_pins.pulse(0, 2, 6, 2);
      mdl[9] = 32'hABCD;
      rc(ca(1));
      rc(ca(2));
      mdl[18] = 32'h40;
      rc(`GPTU_FLAGS_OFS);
      // reload a on latch rise, b on latch fall: high 4 steps, low 8 steps
      wr(ca(0), 32'hFFFC);
      wr(ca(2), 32'hFFF8);
      wr(ca(1), 32'hFFFC);
      wr(cr(0), 32'hA00);
      wr(cr(2), 32'h1200);
      wr(cr(1), 32'h10010);
      repeat (20) @(posedge clk);
      n = 0;
      repeat (96) @(posedge clk) n += ctog;
      chk(n, 32);
      wr(cr(1), 0);
      wr(cr(0), 0);
      wr(cr(2), 0);
      wr(`GPTU_FLAGS_OFS, 32'hFF);
      $display("test capture reload done");
      // sources: capture pin, core timer pin, core direction pin, both core pins
      for (int s = 0; s < 4; s++)
      begin
         wr(ca(3), 32'h70 + s);
         wr(`GPTU_CRCTRL_OFS, 32'h14 + s);
         u_gptu_pins.pulse((s == 0) ? 2 : (s - 1) % 2, 1, 6, 2);
         mdl[16] = 32'h70 + s;
         mdl[11] = 0;
         rc(`GPTU_CAPTURE_RELOAD_REG_OFS);
         rc(ca(3));
      end
      mdl[18] = 32'h20;
      rc(`GPTU_FLAGS_OFS);
      // second core wraps into the captured value, not zero; six steps in twelve cycles
      wr(`GPTU_CRCTRL_OFS, 32'h20);
      wr(ca(4), 32'hFFFE);
      wr(cr(4), 32'h10);
      repeat (10) @(posedge clk);
      mdl[12] = mdl[16] + 4;
      rc(ca(4));
      $display("test second group capture done");
      stop_test();
   end
endmodule : gptu_top_tb
